// ### logic/sdl_dac_end.sv
// dac end: input shift register on the shift clock, dac latch on clk_sys
// assumes a free-running shift clock from the host and clk_sys for the latch side
//
// What this block does, and what it expects of the host
// - shift serial bit on falling edge while framed
// - load strobe fall copies low twelve bits
// - strobe held low: load after sixteen bits
// - latched code is two's complement
// - host keeps shift clock at most 5 MHz
// - host keeps shift clock duty 40/60..60/40
// - frame rises before load strobe falls
// - load strobe rises before next frame falls
// - shift clock fall while unframed restarts the bit count
// - automatic load on sixteenth falling edge
// - output follows only the dac latch
`timescale 1ns/1ps
module sdl_dac_end (
  input wire logic clk_sys,
  input wire logic rst,
  sdl_link_if.dac link,
  output logic [11:0] dac_code,
  output logic [11:0] dac_level,
  output logic update,
  output logic word_pending,
  output logic overrun,
  output logic frame_abort
);

  // link domain state
  logic rst_l1_r;
  logic rst_l2_r;
  logic [15:0] sh_r;
  logic [15:0] sh_nxt;
  logic [sdl_pkg::CNT_W-1:0] cnt_r;
  logic [sdl_pkg::CNT_W-1:0] cnt_nxt;
  logic [15:0] hold_r;
  logic [15:0] hold_nxt;
  logic full_tgl_r;
  logic full_tgl_nxt;
  logic abort_tgl_r;
  logic abort_tgl_nxt;
  logic [15:0] sh_in;

  // system domain state
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  logic [3:0] prev_r;
  logic [11:0] code_r;
  logic [11:0] code_nxt;
  logic [11:0] level_r;
  logic [11:0] level_nxt;
  logic update_r;
  logic update_nxt;
  logic valid_r;
  logic valid_nxt;
  logic overrun_r;
  logic overrun_nxt;
  logic abort_r;
  logic abort_nxt;

  // decoded system domain events
  logic new_word;
  logic abort_evt;
  logic strobe_low;
  logic strobe_fall;
  logic frame_fall;
  logic auto_load;
  logic edge_load;
  logic load;

  // link reset stretch, system domain
  localparam logic [7:0] LRST_LAST = 8'(sdl_pkg::LINK_RST_CYC);
  logic [7:0] lrst_cnt_r;
  logic [7:0] lrst_cnt_nxt;
  logic lrst_r;
  logic lrst_nxt;

  // rst held on past release: the shift clock only starts then
  always_comb begin
    lrst_cnt_nxt = lrst_cnt_r;
    lrst_nxt = 1'b0;
    if (lrst_cnt_r != LRST_LAST) begin
      lrst_cnt_nxt = lrst_cnt_r + 8'h01;
      lrst_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lrst_cnt_r <= 8'h00;
      lrst_r <= 1'b1;
    end else begin
      lrst_cnt_r <= lrst_cnt_nxt;
      lrst_r <= lrst_nxt;
    end
  end

  // stretched reset carried into the link domain on its own edges
  always_ff @(negedge link.shift_clk) begin
    rst_l1_r <= lrst_r;
    rst_l2_r <= rst_l1_r;
  end

  assign sh_in = {sh_r[14:0], link.serial_input};

  // shift register and bit counter
  always_comb begin
    sh_nxt = sh_r;
    cnt_nxt = cnt_r;
    hold_nxt = hold_r;
    full_tgl_nxt = full_tgl_r;
    abort_tgl_nxt = abort_tgl_r;
    if (rst_l2_r) begin
      sh_nxt = sdl_pkg::WORD_RST;
      cnt_nxt = sdl_pkg::CNT_RST;
      hold_nxt = sdl_pkg::WORD_RST;
      full_tgl_nxt = 1'b0;
      abort_tgl_nxt = 1'b0;
    end else if (link.frame_n) begin
      // unframed edge: no shift, count back to start
      cnt_nxt = sdl_pkg::CNT_RST;
      if (cnt_r != sdl_pkg::CNT_RST) begin
        abort_tgl_nxt = ~abort_tgl_r;
      end
    end else begin
      sh_nxt = sh_in;
      if (cnt_r == sdl_pkg::LAST_BIT) begin
        // sixteenth edge: word handed to the latch side
        hold_nxt = sh_in;
        full_tgl_nxt = ~full_tgl_r;
        cnt_nxt = sdl_pkg::CNT_RST;
      end else begin
        cnt_nxt = cnt_r + 5'h01;
      end
    end
  end

  always_ff @(negedge link.shift_clk) begin
    sh_r <= sh_nxt;
    cnt_r <= cnt_nxt;
    hold_r <= hold_nxt;
    full_tgl_r <= full_tgl_nxt;
    abort_tgl_r <= abort_tgl_nxt;
  end

  // two-flop synchronisers: word toggle, abort toggle, strobe, frame
  // held idle until the stretched link reset lrst_r ends
  always_ff @(posedge clk_sys) begin
    if (rst || lrst_r) begin
      sync1_r <= sdl_pkg::SYNC_IDLE;
      sync2_r <= sdl_pkg::SYNC_IDLE;
      prev_r <= sdl_pkg::SYNC_IDLE;
    end else begin
      sync1_r <= {link.frame_n, link.latch_load_strobe_n, abort_tgl_r, full_tgl_r};
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  // event decode
  always_comb begin
    new_word = sync2_r[0] ^ prev_r[0];
    abort_evt = sync2_r[1] ^ prev_r[1];
    strobe_low = ~sync2_r[2];
    strobe_fall = prev_r[2] & ~sync2_r[2];
    frame_fall = prev_r[3] & ~sync2_r[3];
    auto_load = new_word & strobe_low;
    edge_load = strobe_fall & (valid_r | new_word);
    load = auto_load | edge_load;
  end

  // dac latch; only a load changes the output
  always_comb begin
    code_nxt = code_r;
    level_nxt = level_r;
    if (load) begin
      code_nxt = hold_r[11:0];
      level_nxt = hold_r[11:0] ^ sdl_pkg::SIGN_FLIP;
    end
    update_nxt = load;
  end

  // word status; a new word wins over a frame-start clear
  always_comb begin
    valid_nxt = (valid_r & ~frame_fall & ~load) | (new_word & ~load);
    overrun_nxt = new_word & valid_r & ~load;
    abort_nxt = abort_evt;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      code_r <= sdl_pkg::CODE_RST;
      level_r <= sdl_pkg::SIGN_FLIP;
      update_r <= 1'b0;
      valid_r <= 1'b0;
      overrun_r <= 1'b0;
      abort_r <= 1'b0;
    end else begin
      code_r <= code_nxt;
      level_r <= level_nxt;
      update_r <= update_nxt;
      valid_r <= valid_nxt;
      overrun_r <= overrun_nxt;
      abort_r <= abort_nxt;
    end
  end

  assign dac_code = code_r;
  assign dac_level = level_r;
  assign update = update_r;
  assign word_pending = valid_r;
  assign overrun = overrun_r;
  assign frame_abort = abort_r;

endmodule

// ### logic/sdl_host_end.sv
// host end: serial port that frames, shifts and, outside auto mode, strobes one code per request
// assumes clk_sys at the system rate; shift clock made here by a divider
`timescale 1ns/1ps
module sdl_host_end (
  input wire logic clk_sys,
  input wire logic rst,
  sdl_link_if.host link,
  input wire logic req_valid,
  input wire logic [11:0] req_code,
  input wire logic auto_mode,
  output logic req_ready,
  output logic done
);

  localparam logic [4:0] DIV_LAST = 5'(sdl_pkg::SCLK_DIV - 1);
  localparam logic [4:0] DIV_FALL = 5'(sdl_pkg::SCLK_HALF - 1);
  localparam logic [4:0] PULSE_END = 5'(sdl_pkg::LOAD_PULSE_CYC);

  logic [4:0] div_r;
  logic [4:0] div_nxt;
  logic sclk_r;
  logic sclk_nxt;
  logic rise;
  sdl_pkg::sdl_host_state_t state_r;
  sdl_pkg::sdl_host_state_t state_nxt;
  logic [15:0] sh_r;
  logic [15:0] sh_nxt;
  logic [sdl_pkg::CNT_W-1:0] bit_r;
  logic [sdl_pkg::CNT_W-1:0] bit_nxt;
  logic [4:0] cnt_r;
  logic [4:0] cnt_nxt;
  logic frame_n_r;
  logic frame_n_nxt;
  logic sdo_r;
  logic sdo_nxt;
  logic strobe_n_r;
  logic strobe_n_nxt;
  logic auto_r;
  logic auto_nxt;
  logic ready_r;
  logic ready_nxt;
  logic done_r;
  logic done_nxt;

  // free-running divider, 50 % duty at no more than the top rate
  always_comb begin
    rise = (div_r == DIV_LAST);
    div_nxt = rise ? 5'h00 : div_r + 5'h01;
    sclk_nxt = sclk_r;
    if (div_r == DIV_FALL) begin
      sclk_nxt = 1'b0;
    end else if (rise) begin
      sclk_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      div_r <= 5'h00;
      sclk_r <= 1'b1;
    end else begin
      div_r <= div_nxt;
      sclk_r <= sclk_nxt;
    end
  end

  // frame sequencer; frame and data pins change on the shift clock rising edge, the load strobe on any clk_sys cycle
  always_comb begin
    state_nxt = state_r;
    sh_nxt = sh_r;
    bit_nxt = bit_r;
    cnt_nxt = cnt_r;
    frame_n_nxt = frame_n_r;
    sdo_nxt = sdo_r;
    strobe_n_nxt = strobe_n_r;
    auto_nxt = auto_r;
    ready_nxt = ready_r;
    done_nxt = 1'b0;
    case (state_r)
      sdl_pkg::ST_IDLE: begin
        strobe_n_nxt = ~auto_r;
        if (req_valid && ready_r) begin
          sh_nxt = {sdl_pkg::PAD_BITS, req_code};
          auto_nxt = auto_mode;
          ready_nxt = 1'b0;
          state_nxt = sdl_pkg::ST_WAIT;
        end
      end
      sdl_pkg::ST_WAIT: begin
        strobe_n_nxt = ~auto_r;
        if (rise && (strobe_n_r == ~auto_r)) begin
          frame_n_nxt = 1'b0;
          sdo_nxt = sh_r[15];
          sh_nxt = {sh_r[14:0], 1'b0};
          bit_nxt = sdl_pkg::CNT_RST;
          state_nxt = sdl_pkg::ST_SHIFT;
        end
      end
      sdl_pkg::ST_SHIFT: begin
        if (rise) begin
          if (bit_r == sdl_pkg::LAST_BIT) begin
            frame_n_nxt = 1'b1;
            cnt_nxt = 5'h00;
            state_nxt = auto_r ? sdl_pkg::ST_DONE : sdl_pkg::ST_LOAD;
          end else begin
            sdo_nxt = sh_r[15];
            sh_nxt = {sh_r[14:0], 1'b0};
            bit_nxt = bit_r + 5'h01;
          end
        end
      end
      sdl_pkg::ST_LOAD: begin
        strobe_n_nxt = 1'b0;
        cnt_nxt = cnt_r + 5'h01;
        if (cnt_r == PULSE_END) begin
          strobe_n_nxt = 1'b1;
          state_nxt = sdl_pkg::ST_DONE;
        end
      end
      sdl_pkg::ST_DONE: begin
        done_nxt = 1'b1;
        ready_nxt = 1'b1;
        state_nxt = sdl_pkg::ST_IDLE;
      end
      default: begin
        state_nxt = sdl_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_r <= sdl_pkg::ST_IDLE;
      sh_r <= sdl_pkg::WORD_RST;
      bit_r <= sdl_pkg::CNT_RST;
      cnt_r <= 5'h00;
      frame_n_r <= 1'b1;
      sdo_r <= 1'b0;
      strobe_n_r <= 1'b1;
      auto_r <= 1'b0;
      ready_r <= 1'b1;
      done_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      sh_r <= sh_nxt;
      bit_r <= bit_nxt;
      cnt_r <= cnt_nxt;
      frame_n_r <= frame_n_nxt;
      sdo_r <= sdo_nxt;
      strobe_n_r <= strobe_n_nxt;
      auto_r <= auto_nxt;
      ready_r <= ready_nxt;
      done_r <= done_nxt;
    end
  end

  assign link.shift_clk = sclk_r;
  assign link.frame_n = frame_n_r;
  assign link.serial_input = sdo_r;
  assign link.latch_load_strobe_n = strobe_n_r;
  assign req_ready = ready_r;
  assign done = done_r;

endmodule

// ### logic/sdl_link_if.sv
// the four wires between the host serial port and the dac input logic
// assumes the host end drives every wire and the dac end only listens
`timescale 1ns/1ps
interface sdl_link_if;
  logic frame_n;
  logic shift_clk;
  logic serial_input;
  logic latch_load_strobe_n;
  modport host (
    output frame_n,
    output shift_clk,
    output serial_input,
    output latch_load_strobe_n
  );
  modport dac (
    input frame_n,
    input shift_clk,
    input serial_input,
    input latch_load_strobe_n
  );
endinterface

// ### logic/sdl_pkg.sv
// constants and types shared by both ends of the serial dac word loader
// assumes both ends run clk_sys at the 100 MHz system rate
package sdl_pkg;
  localparam int WORD_BITS = 16;
  localparam int CODE_BITS = 12;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] LAST_BIT = 5'h0F;
  localparam logic [CNT_W-1:0] CNT_RST = 5'h00;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [11:0] CODE_RST = 12'h000;
  localparam logic [11:0] SIGN_FLIP = 12'h800;
  localparam logic [3:0] PAD_BITS = 4'h0;
  localparam int SYS_CLK_HZ = 100000000;
  localparam int SYS_PERIOD_NS = 10;
  localparam int SCLK_MAX_HZ = 5000000;
  localparam int SCLK_DIV = (SYS_CLK_HZ + SCLK_MAX_HZ - 1) / SCLK_MAX_HZ;
  localparam int SCLK_HALF = SCLK_DIV / 2;
  localparam int LINK_RST_CYC = 5 * SCLK_DIV;
  localparam int LOAD_PULSE_NS = 20;
  localparam int LOAD_PULSE_CYC = (LOAD_PULSE_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam logic [3:0] SYNC_IDLE = 4'hC;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WAIT,
    ST_SHIFT,
    ST_LOAD,
    ST_DONE
  } sdl_host_state_t;
endpackage

// ### testbench/sdl_link_properties.sv
// link checker: timing of the four wires that the host end drives
// assumes clk_sys and rst of both ends; instantiated beside the interface
`timescale 1ns/1ps
module sdl_link_properties (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic frame_n,
  input wire logic shift_clk,
  input wire logic serial_input,
  input wire logic latch_load_strobe_n
);
  logic [4:0] fall_cnt_r;
  logic [4:0] fall_cnt_nxt;
  logic clk_q_r;
  logic frm_q_r;
  // framed falling edges of the shift clock
  always_comb begin
    fall_cnt_nxt = fall_cnt_r;
    if (rst || (frm_q_r && !frame_n)) begin
      fall_cnt_nxt = 5'h00;
    end else if (clk_q_r && !shift_clk && !frame_n) begin
      fall_cnt_nxt = fall_cnt_r + 5'h01;
    end
  end
  always_ff @(posedge clk_sys) begin
    fall_cnt_r <= fall_cnt_nxt;
    clk_q_r <= shift_clk;
    frm_q_r <= frame_n;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_hi_half;
    shift_clk [*8] ##1 shift_clk;
  endsequence
  sequence s_lo_half;
    !shift_clk [*8] ##1 !shift_clk;
  endsequence
  AST_CLK_HIGH: assert property ($rose(shift_clk) |=> s_hi_half ##1 !shift_clk)
    else $error("shift clock high phase wrong");
  AST_CLK_LOW: assert property ($fell(shift_clk) |=> s_lo_half ##1 shift_clk)
    else $error("shift clock low phase wrong");
  AST_STROBE_FALL: assert property ($fell(latch_load_strobe_n) |-> frame_n)
    else $error("load strobe fell inside a frame");
  AST_STROBE_RISE: assert property ($rose(latch_load_strobe_n) |-> frame_n)
    else $error("load strobe rose inside a frame");
  AST_STROBE_WIDTH: assert property ($rose(latch_load_strobe_n) |-> !$past(latch_load_strobe_n, 2))
    else $error("load strobe pulse too short");
  AST_FRAME_EDGE: assert property ($changed(frame_n) |-> shift_clk)
    else $error("frame changed while shift clock low");
  AST_DATA_EDGE: assert property ($changed(serial_input) |-> shift_clk)
    else $error("serial data changed while shift clock low");
  AST_SIXTEEN: assert property ($rose(frame_n) |-> fall_cnt_r == 5'h10)
    else $error("frame did not carry sixteen bits");
endmodule

// ### testbench/serial_dac_word_loader_tb.sv
// bench: host end feeds dac end over the link; codes checked at the latch
// assumes logic/ files and the link checker are compiled first
`timescale 1ns/1ps
module serial_dac_word_loader_tb;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  logic [11:0] req_code = 12'h000;
  logic auto_mode = 1'b0;
  logic req_ready, done, update, word_pending, overrun, frame_abort;
  logic [11:0] dac_code, dac_level;
  logic [11:0] held = 12'h000;
  logic [12:0] exp_q[$];
  logic [12:0] exp_w;
  logic pend_seen = 1'b0;
  int err_total = 0;
  int n_tests = 0;
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  sdl_link_if sdl_link_if_i ();
  sdl_host_end sdl_host_end_i (.clk_sys(clk_sys), .rst(rst), .link(sdl_link_if_i), .req_valid(req_valid),
    .req_code(req_code), .auto_mode(auto_mode), .req_ready(req_ready), .done(done));
  sdl_dac_end sdl_dac_end_i (.clk_sys(clk_sys), .rst(rst), .link(sdl_link_if_i), .dac_code(dac_code),
    .dac_level(dac_level), .update(update), .word_pending(word_pending), .overrun(overrun),
    .frame_abort(frame_abort));
  sdl_link_properties sdl_link_properties_i (.clk_sys(clk_sys), .rst(rst), .frame_n(sdl_link_if_i.frame_n),
    .shift_clk(sdl_link_if_i.shift_clk), .serial_input(sdl_link_if_i.serial_input),
    .latch_load_strobe_n(sdl_link_if_i.latch_load_strobe_n));
  task automatic stop_test();
    if (err_total == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic hang();
    err_total++;
    stop_test();
  endtask
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected flag at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one request, held until taken, then wait for done
  task automatic send(input logic [11:0] code, input logic am);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 1000) begin
      @(negedge clk_sys);
      n++;
    end
    if (n == 1000) hang();
    req_valid = 1'b1;
    req_code = code;
    auto_mode = am;
    exp_q.push_back({am, code});
    @(negedge clk_sys);
    req_valid = 1'b0;
    req_code = 12'($urandom);
    n = 0;
    while (done !== 1'b1 && n < 1000) begin
      @(negedge clk_sys);
      n++;
    end
    if (n == 1000) hang();
  endtask
  // latch watcher: each update takes the oldest expected code
  always @(negedge clk_sys) begin
    if (!rst && update === 1'b1) begin
      if (exp_q.size() == 0) begin
        hang();
      end else begin
        exp_w = exp_q.pop_front();
        chk(dac_code, exp_w[11:0]);
        chk(dac_level, {~exp_w[11], exp_w[10:0]});
        chk_flag(pend_seen, ~exp_w[12]);
        chk_flag(word_pending, 1'b0);
        held = exp_w[11:0];
        pend_seen = 1'b0;
      end
    end else if (!rst && dac_code !== held) begin
      chk(dac_code, held);
    end
    if (!rst && word_pending === 1'b1) pend_seen = 1'b1;
    if (!rst) chk_flag(overrun | frame_abort, 1'b0);
  end
  initial begin
    logic [11:0] edge_codes [4];
    int n;
    edge_codes = '{12'h800, 12'h7FF, 12'h000, 12'hFFF};
    void'($urandom(32'hA609));
    repeat (3) @(negedge clk_sys);
    rst = 1'b0;
    repeat (200) @(negedge clk_sys);
    for (int i = 0; i < 8; i++) begin
      send(edge_codes[i % 4], 1'(i / 4));
    end
    repeat (8) send(12'($urandom), 1'($urandom));
    n = 0;
    while (exp_q.size() != 0 && n < 50) begin
      @(negedge clk_sys);
      n++;
    end
    if (exp_q.size() != 0) err_total++;
    stop_test();
  end
endmodule
